//--- hdl/catch_pkg.sv
/*
  Constants shared by the spinning motor speed search sequencer.
  Assumes a 10 MHz system clock and settings presented as plain integers.
*/
package catch_pkg;
  // ==========================================================================
  // Clock and time scaling
  // ==========================================================================
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned MS_PER_S = 1000;
  localparam logic [31:0] CYCLES_PER_MS = 32'(CLK_HZ / MS_PER_S);

  // ==========================================================================
  // Setting codes and defaults
  // ==========================================================================
  localparam logic [1:0] TRIG_ALWAYS = 2'h0;
  localparam logic [1:0] TRIG_TRIP_OR_POWER = 2'h1;
  localparam logic [1:0] TRIG_TRIP = 2'h2;
  localparam logic DIR_BIDIR = 1'h0;
  localparam logic DIR_UNIDIR = 1'h1;
  localparam logic [9:0] SEARCH_VOLTS_DEF = 10'h05a;   // 9.0 % in tenths.
  localparam logic [9:0] SEARCH_BOOST_DEF = 10'h190;   // 40.0 % in tenths.
  localparam logic [9:0] VOLTS_MAX = 10'h3e8;          // 100.0 % in tenths.
  localparam logic [9:0] BOOST_MAX = 10'h1f4;          // 50.0 % in tenths.
  localparam logic [15:0] SEARCH_TIME_MS_DEF = 16'h0bb8; // 3.000 s.
  localparam logic [15:0] REFLUX_TIME_MS_DEF = 16'h07d0; // 2.000 s.
  localparam logic [15:0] SEARCH_TIME_MS_MIN = 16'h0064;
  localparam logic [15:0] SEARCH_TIME_MS_MAX = 16'hea60;
  localparam logic [15:0] REFLUX_TIME_MS_MIN = 16'h0064;
  localparam logic [15:0] REFLUX_TIME_MS_MAX = 16'h2710;
  localparam logic [9:0] MIN_SPEED_DEF = 10'h005;      // 5 Hz.
  localparam logic [9:0] MIN_SPEED_MAX = 10'h1f4;      // 500 Hz.
endpackage

//--- hdl/speed_search.sv
/*
  Speed search sequencer that restarts the inverter into a spinning
  induction motor: sweeps frequency down, detects regeneration, refluxes.
  Assumes all inputs synchronous to clk_sys and settings held steady during
  a search; frequencies are unsigned Hz, voltages in tenths of a percent.
*/
// Contract
// - Search only with induction motor selected.
// - Separate scalar and vector enables, default off.
// - Trigger mode: always, trip-or-powerup, trip.
// - Direction mode: bidirectional or single direction.
// - Scalar search voltage 0..100 %, default 9.
// - Scalar search sweep time 0.1..60 s.
// - Sweep frequency down from maximum with search voltage.
// - Motoring-to-regenerating ends search, captures frequency.
// - Below minimum speed: fail, ramp from zero.
// - Scalar reflux ramps voltage over set time.
// - Bidirectional retries reverse after first failure.
module speed_search #(
  parameter int unsigned FREQ_W = 10,
  parameter logic [9:0] MAX_FREQ = 10'h1f4
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic start_req,
  input wire logic last_stop_uncontrolled,
  input wire logic first_start_after_power,
  input wire logic induction_motor_select,
  input wire logic vector_mode,
  input wire logic scalar_catch_enable,
  input wire logic vector_catch_enable,
  input wire logic [1:0] trigger_mode,
  input wire logic direction_mode,
  input wire logic setpoint_reverse,
  input wire logic [9:0] search_volts,
  input wire logic [9:0] search_boost,
  input wire logic [15:0] search_time_ms,
  input wire logic [FREQ_W-1:0] min_search_speed,
  input wire logic [15:0] reflux_time_ms,
  input wire logic regenerating,
  output logic searching,
  output logic refluxing,
  output logic [FREQ_W-1:0] search_freq,
  output logic search_reverse,
  output logic [9:0] volts_demand,
  output logic [9:0] boost_demand,
  output logic catch_done,
  output logic catch_ok,
  output logic catch_failed,
  output logic [FREQ_W-1:0] start_freq,
  output logic start_reverse
);
  // The sequence has three phases only: waiting for a start, sweeping the
  // frequency down, and bringing the flux back up at the found speed.
  // A failed sweep goes straight back to waiting; the drive's own ramp then
  // starts from zero, so no separate failure state is needed.
  typedef enum logic [1:0] {IDLE, SEARCH, REFLUX} state_e;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Clamp a setting into its legal range; out-of-range writes are bounded.
  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [9:0] clamp10(input logic [9:0] v, input logic [9:0] hi);
    clamp10 = (v > hi) ? hi : v;
  endfunction

  // Sequencer state and the shared timebase.
  // The tick counter divides the system clock down to milliseconds, so all
  // user times are in whole milliseconds; sub-millisecond precision is traded
  // for a single narrow counter that serves every phase.
  state_e state;
  state_e next_state;
  logic [31:0] tick;
  logic [15:0] ms_cnt;
  logic second_pass;
  logic regen_prev;

  // ==========================================================================
  // Decoding
  // ==========================================================================
  // Vector mode uses its own enable and fixed defaults; the tuning inputs other than
  // direction_mode only shape the scalar sequence.
  wire logic scalar = !vector_mode;
  wire logic enabled = induction_motor_select && (scalar ? scalar_catch_enable : vector_catch_enable);
  wire logic [1:0] trig_eff = scalar ? trigger_mode : catch_pkg::TRIG_ALWAYS;
  wire logic trig_hit = (trig_eff == catch_pkg::TRIG_ALWAYS)
    || (trig_eff == catch_pkg::TRIG_TRIP_OR_POWER && (last_stop_uncontrolled || first_start_after_power))
    || (trig_eff == catch_pkg::TRIG_TRIP && last_stop_uncontrolled);
  wire logic launch = start_req && enabled && trig_hit;
  wire logic [9:0] volts_eff = scalar ? clamp10(search_volts, catch_pkg::VOLTS_MAX)
    : catch_pkg::SEARCH_VOLTS_DEF;
  wire logic [9:0] boost_eff = scalar ? clamp10(search_boost, catch_pkg::BOOST_MAX)
    : catch_pkg::SEARCH_BOOST_DEF;
  wire logic [15:0] stime = scalar ? clamp16(search_time_ms, catch_pkg::SEARCH_TIME_MS_MIN,
    catch_pkg::SEARCH_TIME_MS_MAX) : catch_pkg::SEARCH_TIME_MS_DEF;
  wire logic [15:0] rtime = scalar ? clamp16(reflux_time_ms, catch_pkg::REFLUX_TIME_MS_MIN,
    catch_pkg::REFLUX_TIME_MS_MAX) : catch_pkg::REFLUX_TIME_MS_DEF;
  wire logic [FREQ_W-1:0] min_eff = scalar
    ? FREQ_W'(clamp10(10'(min_search_speed), catch_pkg::MIN_SPEED_MAX))
    : FREQ_W'(catch_pkg::MIN_SPEED_DEF);
  wire logic ms_tick = (tick == catch_pkg::CYCLES_PER_MS - 32'h1);
  // One frequency step spreads the full sweep across the search time, but a step never lasts less than one millisecond.
  wire logic [31:0] step_ms = (32'(stime) / 32'(MAX_FREQ) == 32'h0) ? 32'h1 : 32'(stime) / 32'(MAX_FREQ);
  wire logic step = ms_tick && (32'(ms_cnt) + 32'h1 >= step_ms);
  wire logic regen_edge = regenerating && !regen_prev;
  wire logic below_min = (search_freq < min_eff);
  // Only a bidirectional setting earns the reverse pass; a single-direction
  // search ends at the first fall below the minimum speed.
  wire logic retry = below_min && !second_pass && (direction_mode == catch_pkg::DIR_BIDIR);
  wire logic reflux_end = ms_tick && (ms_cnt + 16'h1 >= rtime);
  // Voltage rises linearly from search level to full over the reflux time.
  wire logic [31:0] ramp_num = 32'(catch_pkg::VOLTS_MAX - volts_eff) * 32'(ms_cnt);
  wire logic [9:0] reflux_volts = volts_eff + 10'(ramp_num / 32'(rtime));

  // Next state selection.
  // Regeneration is tested before the minimum speed, so a catch found on the
  // very step that also crosses the minimum still counts as a success.
  always_comb begin
    next_state = state;
    unique case (state)
      IDLE: if (launch) next_state = SEARCH;
      SEARCH: begin
        if (regen_edge) next_state = REFLUX;
        else if (below_min && !retry) next_state = IDLE;
      end
      REFLUX: if (reflux_end) next_state = IDLE;
    endcase
  end

  // ==========================================================================
  // Sequencer registers
  // ==========================================================================
  // State, timebase and regeneration edge history.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= IDLE;
      tick <= 32'h0;
      regen_prev <= 1'b0;
    end else begin
      state <= next_state;
      tick <= (ms_tick || state != next_state) ? 32'h0 : tick + 32'h1;
      regen_prev <= regenerating;
    end
  end

  // Millisecond counter reused as step timer and reflux timer.
  // It restarts on every phase change, so the reflux time is measured from
  // the capture and not from the last sweep step.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ms_cnt <= 16'h0;
    end else if (state != next_state || (state == SEARCH && step)) begin
      ms_cnt <= 16'h0;
    end else if (ms_tick) begin
      ms_cnt <= ms_cnt + 16'h1;
    end
  end

  // Frequency sweep, direction and pass bookkeeping.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      search_freq <= '0;
      search_reverse <= 1'b0;
      second_pass <= 1'b0;
    end else if (state == IDLE && launch) begin
      search_freq <= MAX_FREQ[FREQ_W-1:0];
      search_reverse <= setpoint_reverse;
      second_pass <= 1'b0;
    end else if (state == SEARCH && !regen_edge) begin
      if (retry) begin
        search_freq <= MAX_FREQ[FREQ_W-1:0];
        search_reverse <= !search_reverse;
        second_pass <= 1'b1;
      end else if (step && search_freq != '0) begin
        search_freq <= search_freq - FREQ_W'(1);
      end
    end
  end

  // Outputs, all registered.
  // Demands follow the next state so that they change on the same edge as
  // the phase flags; the voltage enters reflux with no dip to zero, but it starts
  // at the search level only when the step count left from the sweep is zero.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      searching <= 1'b0;
      refluxing <= 1'b0;
      volts_demand <= 10'h0;
      boost_demand <= 10'h0;
      catch_done <= 1'b0;
      catch_ok <= 1'b0;
      catch_failed <= 1'b0;
      start_freq <= '0;
      start_reverse <= 1'b0;
    end else begin
      searching <= (next_state == SEARCH);
      refluxing <= (next_state == REFLUX);
      volts_demand <= (next_state == SEARCH) ? volts_eff
        : ((next_state == REFLUX) ? reflux_volts : 10'h0);
      boost_demand <= (next_state == SEARCH && scalar) ? boost_eff : 10'h0;
      catch_done <= (state != IDLE) && (next_state == IDLE);
      catch_ok <= (state == REFLUX) && reflux_end;
      catch_failed <= (state == SEARCH) && (next_state == IDLE);
      if (state == SEARCH && regen_edge) begin
        start_freq <= search_freq;
        start_reverse <= search_reverse;
      end else if (state == SEARCH && next_state == IDLE) begin
        start_freq <= '0;
        start_reverse <= setpoint_reverse;
      end
    end
  end
endmodule

//--- dv/speed_search_properties.sv
/* Port checker for the speed search sequencer.
   Bound from the bench top file; sees only the top module's ports. */
module speed_search_properties #(
  parameter int unsigned FREQ_W = 10,
  parameter logic [9:0] MAX_FREQ = 10'h1f4
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic induction_motor_select,
  input wire logic vector_mode,
  input wire logic [9:0] search_volts,
  input wire logic [9:0] search_boost,
  input wire logic regenerating,
  input wire logic searching,
  input wire logic refluxing,
  input wire logic [FREQ_W-1:0] search_freq,
  input wire logic [9:0] volts_demand,
  input wire logic [9:0] boost_demand,
  input wire logic catch_done,
  input wire logic catch_ok,
  input wire logic catch_failed,
  input wire logic [FREQ_W-1:0] start_freq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Sequencer relations; all are muted while reset is low.
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_needs_induction: assert property ($rose(searching) |-> $past(induction_motor_select))
    else $error("search began without induction motor");
  a_start_at_max: assert property ($rose(searching) |-> search_freq == MAX_FREQ)
    else $error("sweep did not start at maximum");
  // A second pass restarts at maximum, so that value is the only rise allowed.
  a_sweep_down: assert property (searching && $past(searching) |->
    search_freq <= $past(search_freq) || search_freq == MAX_FREQ)
    else $error("sweep frequency rose");
  a_search_volts: assert property (searching && !vector_mode |-> volts_demand == search_volts)
    else $error("search voltage wrong");
  a_search_boost: assert property (searching |->
    boost_demand == (vector_mode ? 10'h000 : search_boost))
    else $error("search boost wrong");
  a_regen_ends: assert property (searching && $rose(regenerating) |=> refluxing && !searching)
    else $error("regeneration did not end the search");
  a_speed_taken: assert property ($rose(refluxing) |-> start_freq == $past(search_freq))
    else $error("found speed not captured");
  a_fail_zero: assert property (catch_failed |-> catch_done && !catch_ok && start_freq == 0)
    else $error("failure report wrong");
  a_done_pulse: assert property (catch_done |=> !catch_done)
    else $error("done pulse too long");
  a_ok_after_reflux: assert property (catch_ok |-> catch_done && $past(refluxing))
    else $error("success without reflux");
endmodule

//--- dv/motor_model.sv
/* Spinning induction motor seen through the power stage.
   Assumes the sweep frequency is in Hz, like the shaft speed. */
module motor_model (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic searching,
  input wire logic [9:0] search_freq,
  input wire logic [9:0] motor_speed,
  output logic regenerating
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // The load regenerates once the sweep falls to shaft speed.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst)
      regenerating <= 1'b0;
    else
      regenerating <= searching && (search_freq <= motor_speed);
  end
endmodule

//--- dv/speed_search_tb.sv
/* Self-checking bench for the speed search sequencer.
   Assumes the one-millisecond sweep step of a 100 ms search time. */
module speed_search_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic start_req = 1'b0, last_stop_uncontrolled = 1'b0, first_start_after_power = 1'b0;
  logic induction_motor_select = 1'b1, vector_mode = 1'b0, scalar_catch_enable = 1'b0;
  logic vector_catch_enable = 1'b0, direction_mode = 1'b1, setpoint_reverse = 1'b0;
  logic [1:0] trigger_mode = 2'h0;
  logic [9:0] search_volts = 10'h05a, search_boost = 10'h190, min_search_speed = 10'h1f4, motor_speed = 10'h000;
  logic [15:0] search_time_ms = 16'h0064, reflux_time_ms = 16'h0064;
  logic searching, refluxing, search_reverse, catch_done, catch_ok, catch_failed, start_reverse, regenerating;
  logic [9:0] search_freq, volts_demand, boost_demand, start_freq;
  int n_mismatch = 0;
  int comparisons = 0;
  always #50 clk_sys = ~clk_sys;
  speed_search dut (.*);
  motor_model partner (.*);
  // ==========================================================================
  // Shared tasks.
  task complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task do_reset;
    nrst <= 1'b0;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
  endtask
  // A single-cycle start pulse, then look once the answer has landed.
  task go;
    @(posedge clk_sys);
    start_req <= 1'b1;
    @(posedge clk_sys);
    start_req <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  // Bounded wait: 0 for done, 1 for reflux, 2 for the reverse pass.
  task wait_hi(input int sel, input int bound);
    for (int k = 0; k < bound; k++) begin
      @(posedge clk_sys);
      #1;
      if ((sel == 0 && catch_done === 1'b1) || (sel == 1 && refluxing === 1'b1) || (sel == 2 && search_reverse === 1'b1))
        return;
    end
    n_mismatch++;
    complete_run;
  endtask
  // ==========================================================================
  // Refusals, trigger codes with failing sweeps, reverse pass, then a catch.
  initial begin
    do_reset;
    go;
    chk(searching, 1'b0);
    scalar_catch_enable <= 1'b1;
    induction_motor_select <= 1'b0;
    go;
    chk(searching, 1'b0);
    induction_motor_select <= 1'b1;
    trigger_mode <= 2'h2;
    go;
    chk(searching, 1'b0);
    for (int i = 0; i < 3; i++) begin
      trigger_mode <= 2'(i);
      first_start_after_power <= (i == 1);
      last_stop_uncontrolled <= (i == 2);
      setpoint_reverse <= i[0];
      go;
      chk(searching, 1'b1);
      chk(search_reverse, i[0]);
      chk(search_freq, 10'h1f4);
      chk(volts_demand, search_volts);
      chk(boost_demand, search_boost);
      wait_hi(0, 30000);
      chk(catch_failed, 1'b1);
      chk(start_freq, 10'h000);
      chk(start_reverse, i[0]);
    end
    direction_mode <= 1'b0;
    go;
    wait_hi(2, 15000);
    chk(search_freq, 10'h1f4);
    wait_hi(0, 15000);
    chk(catch_failed, 1'b1);
    min_search_speed <= 10'h005;
    motor_speed <= 10'h1f3;
    go;
    wait_hi(1, 30000);
    chk(start_freq, 10'h1f3);
    chk(volts_demand, search_volts);
    chk(searching, 1'b0);
    chk(start_reverse, 1'b0);
    chk(catch_done, 1'b0);
    // Reflux takes a million cycles, so the run resets in the middle of it.
    do_reset;
    motor_speed <= 10'h000;
    vector_mode <= 1'b1;
    vector_catch_enable <= 1'b1;
    scalar_catch_enable <= 1'b0;
    go;
    chk(searching, 1'b1);
    chk(boost_demand, 10'h000);
    chk(volts_demand, catch_pkg::SEARCH_VOLTS_DEF);
    complete_run;
  end
endmodule
bind speed_search speed_search_properties #(.FREQ_W(FREQ_W), .MAX_FREQ(MAX_FREQ)) props (.*);
